/* File: src/cbpc_top.sv */
// Clock buffer power sequencing, strap capture and Wishbone control registers
//
// Summary of operation
// - Frequency strap low 133.33, high 100 MHz
// - Outputs run one-to-one with reference clock
// - Rate changes reach outputs without glitches
// - Two tri-level straps pick nine bus addresses
// - Power-good rise captures initial strap configuration
// - Afterwards the pin acts as power-down
// - Power-down parks outputs low, then stops oscillator
// - Two low samples park outputs at edge
// - Locked outputs within 1.8 ms of power-good
// - Parked outputs restart within 300 us
// - Bandwidth strap sets mode, read at 7:6
// - Bypass routes reference direct, else through PLL
// - Mode bits override strap only when enabled
// - Readback bits keep the latched strap mode
// - Management port supports standard-mode transfer rate
// - Management lines never held low long
// - General call transactions may be ignored
// - Power-down tri-states management pins, keeps registers
// - Sequencer steps off, delay, wait, run
// - Outputs off until clock, power, release, lock
// - Output active needs enable bit and pin
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module cbpc_top #(
    parameter int N = cbpc_pkg::NUM_OUT,
    parameter logic [cbpc_pkg::CNT_W-1:0] DELAY_CYC = cbpc_pkg::DELAY_CYC,
    parameter logic [cbpc_pkg::CNT_W-1:0] LOCK_CYC = cbpc_pkg::LOCK_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire cbpc_pkg::cbpc_wb_req_t wb_req_i,
    output cbpc_pkg::cbpc_wb_rsp_t wb_rsp_o,
    // Reference clock and power control pin
    input wire logic ref_clk_i,
    input wire logic power_good_in_i,
    // Hardware straps
    input wire logic freq_select_strap_i,
    input wire logic [1:0] addr_strap_high_i,
    input wire logic [1:0] addr_strap_low_i,
    input wire logic [1:0] pll_bw_strap_i,
    // Per-output enable pins, active low
    input wire logic [N-1:0] out_en_n_i,
    // Differential outputs
    output logic [N-1:0] diff_clk_out_p_o,
    output logic [N-1:0] diff_clk_out_n_o,
    // Configuration and status
    output logic [7:0] mgmt_addr_o,
    output logic mgmt_pins_tristate_o,
    output logic [1:0] pll_mode_o,
    output logic freq_100m_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Straps and address are set once,
    // at the first power-good rise;
    // only rst_i clears them
    typedef struct packed {
        cbpc_pkg::cbpc_seq_t seq;
        logic [cbpc_pkg::CNT_W-1:0] cnt;
        logic [4:0] clk_age;
        logic ref_prev;
        logic pg_seen;
        cbpc_pkg::cbpc_straps_t straps;
        logic [1:0] pd_falls;
        logic park;
        logic vco_on;
        logic locked;
        cbpc_pkg::cbpc_mode_t mode;
        logic [1:0] mode_reg;
        logic sw_en;
        logic [N-1:0] oe;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] addr;
        logic tri_mgmt;
    } cbpc_top_state_t;

    localparam int SYNC_W = 2 + $bits(cbpc_pkg::cbpc_straps_t) + N;

    cbpc_top_state_t q;
    cbpc_top_state_t d;
    logic [SYNC_W-1:0] sync_w;
    logic ref_now;
    logic pg_now;
    logic [N-1:0] oe_n_now;
    cbpc_pkg::cbpc_straps_t straps_now;
    logic [N-1:0] gate_p;
    logic [N-1:0] gate_n;
    logic gate_idle;
    logic gate_run;
    logic clk_ok;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Every pin crosses two flops; straps and
    // power pin share them, so captured straps
    // line up with the rise that took them
    cbpc_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({ref_clk_i, power_good_in_i, freq_select_strap_i, addr_strap_high_i,
                  addr_strap_low_i, pll_bw_strap_i, out_en_n_i}),
        .sync_o(sync_w)
    );

    // Unpack the synchronised inputs
    // Order matches the concatenation above
    assign ref_now = sync_w[SYNC_W-1];
    assign pg_now = sync_w[SYNC_W-2];
    assign straps_now = sync_w[SYNC_W-3:N];
    assign oe_n_now = sync_w[N-1:0];
    assign clk_ok = (q.clk_age < cbpc_pkg::CLKDET_CYC);
    assign gate_run = q.locked & ~q.park;

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    // Enables move as the reference rises or clear on a lost clock,
    // so parking leaves no runt on either leg
    cbpc_out_gate #(
        .N(N)
    ) u_gate (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_lvl_i(ref_now),
        .clk_ok_i(clk_ok),
        .run_i(gate_run),
        .en_i(q.oe & ~oe_n_now),
        .diff_p_o(gate_p),
        .diff_n_o(gate_n),
        .idle_o(gate_idle)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Reference edges lag the pin by two cycles;
    // none for CLKDET_CYC cycles is a lost clock
    always_comb begin
        logic rise;
        logic fall;
        logic pd_low;
        logic hit;
        cbpc_pkg::cbpc_mode_t eff_mode;
        logic [31:0] rd;
        d = q;
        rise = ref_now & ~q.ref_prev;
        fall = ~ref_now & q.ref_prev;
        pd_low = q.pg_seen & ~pg_now;
        eff_mode = q.sw_en ? cbpc_pkg::cbpc_bw_mode(q.mode_reg)
                           : cbpc_pkg::cbpc_bw_mode(q.straps.pll_bw_strap);
        hit = wb_req_i.cyc & wb_req_i.stb;
        rd = 32'h0;

        // Reference clock activity detector
        // Age saturates at CLKDET_CYC
        d.ref_prev = ref_now;
        if (rise | fall) begin
            d.clk_age = 5'h0;
        end else if (clk_ok) begin
            d.clk_age = q.clk_age + 5'h1;
        end

        // Strap capture on the first power-good rise only
        // Later strap changes wait for rst_i
        if (!q.pg_seen && pg_now) begin
            d.pg_seen = 1'b1;
            d.straps = straps_now;
            d.addr = cbpc_pkg::cbpc_addr_decode(straps_now.addr_strap_high,
                                               straps_now.addr_strap_low);
        end

        // Power-down sampled on falling reference edges; two in a row park the outputs
        // One low sample alone never parks
        if (!pd_low) begin
            d.pd_falls = 2'h0;
            d.park = 1'b0;
        end else if (fall) begin
            if (q.pd_falls != 2'h2) begin
                d.pd_falls = q.pd_falls + 2'h1;
            end
            if (q.pd_falls != 2'h0) begin
                d.park = 1'b1;
            end
        end

        // Power-up sequencer
        // Mode and override are taken only as the
        // oscillator starts, the warm reset
        case (q.seq)
            cbpc_pkg::ST_OFF: begin
                d.seq = cbpc_pkg::ST_DELAY;
                d.cnt = '0;
            end
            cbpc_pkg::ST_DELAY: begin
                if (q.cnt == DELAY_CYC - 1'b1) begin
                    d.seq = cbpc_pkg::ST_WAIT;
                    d.cnt = '0;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            cbpc_pkg::ST_WAIT: begin
                d.locked = 1'b0;
                if (clk_ok && q.pg_seen && pg_now && !q.park) begin
                    d.vco_on = 1'b1;
                    if (!q.vco_on) begin
                        d.mode = eff_mode;
                        d.cnt = '0;
                    end else if (q.mode == cbpc_pkg::MODE_BYPASS) begin
                        d.locked = 1'b1;
                        d.seq = cbpc_pkg::ST_RUN;
                    end else if (q.cnt == LOCK_CYC - 1'b1) begin
                        d.locked = 1'b1;
                        d.seq = cbpc_pkg::ST_RUN;
                    end else begin
                        d.cnt = q.cnt + 1'b1;
                    end
                end else begin
                    d.cnt = '0;
                end
            end
            cbpc_pkg::ST_RUN: begin
                if (!clk_ok || q.park) begin
                    d.seq = cbpc_pkg::ST_WAIT;
                    d.cnt = '0;
                end
            end
            default: begin
                d.seq = cbpc_pkg::ST_OFF;
            end
        endcase

        // Oscillator stops only once every output has settled low
        // so no leg freezes in a high phase
        if (q.park && gate_idle) begin
            d.vco_on = 1'b0;
            d.locked = 1'b0;
        end

        // Management pins float during power-down; register contents stay
        // The bus keeps working while pins float
        d.tri_mgmt = pd_low;

        // Register read data
        // Reads have no side effects
        case (wb_req_i.adr)
            cbpc_pkg::REG_CTRL: begin
                rd[cbpc_pkg::CTRL_FREQ_BIT] = q.straps.freq_select_strap;
                rd[cbpc_pkg::CTRL_MODE_LSB +: 2] = q.mode_reg;
                rd[cbpc_pkg::CTRL_SWEN_BIT] = q.sw_en;
                rd[cbpc_pkg::CTRL_RB_LSB +: 2] =
                    cbpc_pkg::cbpc_bw_mode(q.straps.pll_bw_strap);
            end
            cbpc_pkg::REG_OE_LO: begin
                rd[7:0] = q.oe[7:0];
            end
            cbpc_pkg::REG_OE_HI: begin
                rd[N-9:0] = q.oe[N-1:8];
            end
            cbpc_pkg::REG_STATUS: begin
                rd[15:0] = {q.addr, q.pg_seen, q.park, q.locked, clk_ok, q.seq};
            end
            default: begin
                rd = 32'h0;
            end
        endcase

        // Classic Wishbone: ack one cycle after the request, write at the ack edge
        // Read data is taken as ack rises and
        // stands while ack is high
        d.ack = hit & ~q.ack;
        if (hit && !q.ack) begin
            d.rdat = rd;
        end
        if (hit && q.ack && wb_req_i.we) begin
            case (wb_req_i.adr)
                cbpc_pkg::REG_CTRL: begin
                    if (wb_req_i.sel[0]) begin
                        d.mode_reg = wb_req_i.dat[cbpc_pkg::CTRL_MODE_LSB +: 2];
                        d.sw_en = wb_req_i.dat[cbpc_pkg::CTRL_SWEN_BIT];
                    end
                end
                cbpc_pkg::REG_OE_LO: begin
                    if (wb_req_i.sel[0]) begin
                        d.oe[7:0] = wb_req_i.dat[7:0];
                    end
                end
                cbpc_pkg::REG_OE_HI: begin
                    if (wb_req_i.sel[0]) begin
                        d.oe[N-1:8] = wb_req_i.dat[N-9:0];
                    end
                end
                default: begin
                    d.oe = q.oe;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset also drops the captured straps,
    // so it counts as a power cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{seq: cbpc_pkg::ST_OFF, cnt: '0, clk_age: cbpc_pkg::CLKDET_CYC,
                   ref_prev: 1'b0, pg_seen: 1'b0, straps: '0, pd_falls: 2'h0,
                   park: 1'b0, vco_on: 1'b0, locked: 1'b0,
                   mode: cbpc_pkg::MODE_PLL_HIGH_BANDWIDTH,
                   mode_reg: cbpc_pkg::CTRL_MODE_RST, sw_en: cbpc_pkg::CTRL_SWEN_RST,
                   oe: cbpc_pkg::OE_RST, ack: 1'b0, rdat: 32'h0, addr: 8'h0,
                   tri_mgmt: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Each output comes from a flop
    assign wb_rsp_o = '{ack: q.ack, dat: q.rdat};
    assign diff_clk_out_p_o = gate_p;
    assign diff_clk_out_n_o = gate_n;
    assign mgmt_addr_o = q.addr;
    assign mgmt_pins_tristate_o = q.tri_mgmt;
    assign pll_mode_o = q.mode;
    assign freq_100m_o = q.straps.freq_select_strap;

endmodule : cbpc_top

/* File: include/cbpc_pkg.sv */
// Shared constants, types and helpers of the clock buffer power and configuration block
package cbpc_pkg;

    // ------------------------------------------------------------------
    // Clocking and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int NUM_OUT = 12;
    localparam int CNT_W = 16;
    localparam int DELAY_NS = 100_000;
    localparam int LOCK_NS = 50_000;
    localparam int POWERUP_MAX_NS = 1_800_000;
    localparam int RESTART_MAX_NS = 300_000;
    localparam logic [CNT_W-1:0] DELAY_CYC = CNT_W'((DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] LOCK_CYC = CNT_W'((LOCK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] CLKDET_CYC = 5'h10;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int WB_AW = 8;
    localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [WB_AW-1:0] REG_OE_LO = 8'h04;
    localparam logic [WB_AW-1:0] REG_OE_HI = 8'h08;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h0C;
    localparam int CTRL_FREQ_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_SWEN_BIT = 3;
    localparam int CTRL_RB_LSB = 6;
    localparam logic [1:0] CTRL_MODE_RST = 2'h3;
    localparam logic CTRL_SWEN_RST = 1'b0;
    localparam logic [NUM_OUT-1:0] OE_RST = 12'hFFF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {TRI_LOW = 2'h0, TRI_MID = 2'h1, TRI_HIGH = 2'h2} cbpc_tri_t;
    typedef enum logic [1:0] {
        MODE_PLL_LOW_BANDWIDTH = 2'h0,
        MODE_BYPASS = 2'h1,
        MODE_PLL_HIGH_BANDWIDTH = 2'h3
    } cbpc_mode_t;
    typedef enum logic [3:0] {
        ST_OFF = 4'h1, ST_DELAY = 4'h2, ST_WAIT = 4'h4, ST_RUN = 4'h8
    } cbpc_seq_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_AW-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cbpc_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cbpc_wb_rsp_t;
    typedef struct packed {
        logic freq_select_strap;
        logic [1:0] addr_strap_high;
        logic [1:0] addr_strap_low;
        logic [1:0] pll_bw_strap;
    } cbpc_straps_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Tri-level strap to PLL mode
    function automatic cbpc_mode_t cbpc_bw_mode(input logic [1:0] lvl);
        case (lvl)
            TRI_LOW: cbpc_bw_mode = MODE_PLL_LOW_BANDWIDTH;
            TRI_MID: cbpc_bw_mode = MODE_BYPASS;
            default: cbpc_bw_mode = MODE_PLL_HIGH_BANDWIDTH;
        endcase
    endfunction : cbpc_bw_mode

    // Two tri-level straps to a management bus address
    function automatic logic [7:0] cbpc_addr_decode(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] idx;
        idx = {(hi == TRI_LOW) ? 2'h0 : (hi == TRI_MID) ? 2'h1 : 2'h2,
               (lo == TRI_LOW) ? 2'h0 : (lo == TRI_MID) ? 2'h1 : 2'h2};
        case (idx)
            4'h0: cbpc_addr_decode = 8'hD8;
            4'h1: cbpc_addr_decode = 8'hDA;
            4'h2: cbpc_addr_decode = 8'hDE;
            4'h4: cbpc_addr_decode = 8'hC2;
            4'h5: cbpc_addr_decode = 8'hC4;
            4'h6: cbpc_addr_decode = 8'hC6;
            4'h8: cbpc_addr_decode = 8'hCA;
            4'h9: cbpc_addr_decode = 8'hCC;
            default: cbpc_addr_decode = 8'hCE;
        endcase
    endfunction : cbpc_addr_decode

endpackage : cbpc_pkg

/* File: src/cbpc_sync.sv */
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module cbpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous input and synchronised output
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } cbpc_sync_state_t;

    cbpc_sync_state_t q;
    cbpc_sync_state_t d;

    // First stage feeds only the second stage
    always_comb begin
        d = q;
        d.meta = async_i;
        d.stable = q.meta;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stable;

endmodule : cbpc_sync

/* File: src/cbpc_out_gate.sv */
// Glitch-free gating of the differential outputs from the sampled reference clock
`timescale 1ns/1ns
module cbpc_out_gate #(
    parameter int N = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Reference clock level and its health
    input wire logic ref_lvl_i,
    input wire logic clk_ok_i,
    // Enables
    input wire logic run_i,
    input wire logic [N-1:0] en_i,
    // Differential outputs
    output logic [N-1:0] diff_p_o,
    output logic [N-1:0] diff_n_o,
    output logic idle_o
);

    typedef struct packed {
        logic lvl;
        logic [N-1:0] act;
        logic [N-1:0] p;
        logic [N-1:0] n;
        logic idle;
    } cbpc_gate_state_t;

    cbpc_gate_state_t q;
    cbpc_gate_state_t d;
    logic [N-1:0] want;

    // Enables change as the reference rises or clear when the clock is lost, so no leg's pulse is cut short
    always_comb begin
        d = q;
        want = run_i ? en_i : '0;
        d.lvl = ref_lvl_i;
        if (!clk_ok_i) begin
            d.act = '0;
        end else if (ref_lvl_i && !q.lvl) begin
            d.act = want;
        end
        d.p = ref_lvl_i ? d.act : '0;
        d.n = ref_lvl_i ? '0 : d.act;
        d.idle = (d.act == '0);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '{lvl: 1'b0, act: '0, p: '0, n: '0, idle: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign diff_p_o = q.p;
    assign diff_n_o = q.n;
    assign idle_o = q.idle;

endmodule : cbpc_out_gate

/* File: sim/cbpc_ref_src.sv */
// Upstream reference clock source model
`timescale 1ns/1ns
module cbpc_ref_src #(
    parameter int HALF_NS = 160
) (
    // Control
    input wire logic en_i,
    // Clock out
    output logic ref_clk_o
);
    // Toggles while enabled, rests low while stopped
    initial begin
        ref_clk_o = 1'b0;
        #7;
        forever begin
            #HALF_NS;
            ref_clk_o = en_i ? ~ref_clk_o : 1'b0;
        end
    end
endmodule : cbpc_ref_src

/* File: sim/cbpc_assertions.sv */
// Concurrent checks on the ports of the clock buffer control block
`timescale 1ns/1ns
module cbpc_assertions #(
    parameter int N = 12,
    parameter logic [cbpc_pkg::CNT_W-1:0] DELAY_CYC = cbpc_pkg::DELAY_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire cbpc_pkg::cbpc_wb_req_t wb_req_i,
    input wire cbpc_pkg::cbpc_wb_rsp_t wb_rsp_o,
    // Pins into the design
    input wire logic ref_clk_i,
    input wire logic power_good_in_i,
    input wire logic freq_select_strap_i,
    input wire logic [1:0] addr_strap_high_i,
    input wire logic [1:0] addr_strap_low_i,
    input wire logic [1:0] pll_bw_strap_i,
    input wire logic [N-1:0] out_en_n_i,
    // Outputs of the design
    input wire logic [N-1:0] diff_clk_out_p_o,
    input wire logic [N-1:0] diff_clk_out_n_o,
    input wire logic [7:0] mgmt_addr_o,
    input wire logic mgmt_pins_tristate_o,
    input wire logic [1:0] pll_mode_o,
    input wire logic freq_100m_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [15:0] up_q;
    logic [3:0] hi_q;
    logic [7:0] low_q;
    logic [N-1:0] any_w;
    assign any_w = diff_clk_out_p_o | diff_clk_out_n_o;

    // Time since reset, high run of output 0, time the pin has been low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_q <= 16'h0000;
            hi_q <= 4'h0;
            low_q <= 8'h00;
        end else begin
            up_q <= up_q + 16'(up_q != 16'hFFFF);
            hi_q <= diff_clk_out_p_o[0] ? hi_q + 4'(hi_q != 4'hF) : 4'h0;
            low_q <= power_good_in_i ? 8'h00 : low_q + 8'(low_q != 8'hFF);
        end
    end

    ack_one_cycle_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    ack_latency_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
        |=> wb_rsp_o.ack)
        else $error("ack not one cycle after request");
    unmapped_zero_a: assert property (wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr > 8'h0C
        |-> wb_rsp_o.dat == 32'h0)
        else $error("unmapped read not zero");
    legs_apart_a: assert property ((diff_clk_out_p_o & diff_clk_out_n_o) == '0)
        else $error("both legs high");
    park_low_a: assert property (low_q >= 8'h28 |-> any_w == '0)
        else $error("outputs not parked");
    quiet_start_a: assert property (up_q < DELAY_CYC |-> any_w == '0)
        else $error("outputs active during start delay");
    high_phase_a: assert property (hi_q <= 4'h5)
        else $error("output high longer than reference phase");
    pins_tristate_a: assert property ($fell(power_good_in_i) && mgmt_addr_o != 8'h00
        |-> ##[1:4] mgmt_pins_tristate_o)
        else $error("pins not tristated");
    straps_hold_a: assert property (mgmt_addr_o != 8'h00
        |=> $stable({mgmt_addr_o, freq_100m_o}))
        else $error("captured straps changed");
    mode_code_a: assert property (pll_mode_o != 2'h2)
        else $error("illegal mode code");
endmodule : cbpc_assertions

bind cbpc_top cbpc_assertions #(.N(N), .DELAY_CYC(DELAY_CYC)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .ref_clk_i(ref_clk_i), .power_good_in_i(power_good_in_i),
    .freq_select_strap_i(freq_select_strap_i), .addr_strap_high_i(addr_strap_high_i),
    .addr_strap_low_i(addr_strap_low_i), .pll_bw_strap_i(pll_bw_strap_i),
    .out_en_n_i(out_en_n_i), .diff_clk_out_p_o(diff_clk_out_p_o),
    .diff_clk_out_n_o(diff_clk_out_n_o), .mgmt_addr_o(mgmt_addr_o),
    .mgmt_pins_tristate_o(mgmt_pins_tristate_o), .pll_mode_o(pll_mode_o),
    .freq_100m_o(freq_100m_o));

/* File: sim/cbpc_tb_top.sv */
// Self-checking bench for the clock buffer control block
`timescale 1ns/1ns
module cbpc_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    cbpc_pkg::cbpc_wb_req_t req = '0;
    cbpc_pkg::cbpc_wb_rsp_t rsp;
    logic ref_en = 1'b1;
    logic ref_clk;
    logic pg = 1'b0;
    // 133 MHz, address straps mid/high, low bandwidth
    cbpc_pkg::cbpc_straps_t st = {1'b0, 2'h1, 2'h2, 2'h0};
    logic [11:0] oe_n = 12'h004;
    logic [11:0] p;
    logic [11:0] n;
    logic [7:0] addr;
    logic tri_st;
    logic f100;
    logic [1:0] mode;
    logic [31:0] rd;
    logic [11:0] seen;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    // Clock, far-side source and design
    always #20 clk_i = ~clk_i;
    cbpc_ref_src ref_u (.en_i(ref_en), .ref_clk_o(ref_clk));
    cbpc_top #(.DELAY_CYC(16'h0014), .LOCK_CYC(16'h001E)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .ref_clk_i(ref_clk), .power_good_in_i(pg),
        .freq_select_strap_i(st.freq_select_strap), .addr_strap_high_i(st.addr_strap_high),
        .addr_strap_low_i(st.addr_strap_low), .pll_bw_strap_i(st.pll_bw_strap),
        .out_en_n_i(oe_n), .diff_clk_out_p_o(p), .diff_clk_out_n_o(n),
        .mgmt_addr_o(addr), .mgmt_pins_tristate_o(tri_st), .pll_mode_o(mode),
        .freq_100m_o(f100));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One classic cycle; holds until ack is seen at a rising edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] got);
        int k;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.ack !== 1'b1);
        got = rsp.dat;
        req <= '0;
        check("ack wait", 32'h2, 32'(k));
    endtask : wb_xfer

    // Collects which outputs showed any high leg
    task automatic watch(input int cyc, output logic [11:0] acc);
        acc = '0;
        repeat (cyc) begin
            @(negedge clk_i);
            acc = acc | p | n;
        end
    endtask : watch

    task automatic wait_run(input int limit, input string what);
        int k;
        k = 0;
        while (p[1] !== 1'b1 && k < limit) begin
            @(negedge clk_i);
            k++;
        end
        check(what, 32'h1, 32'(k < limit));
    endtask : wait_run

    task automatic complete_run();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Run limit
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check("mode reset", 32'h3, 32'(mode));
        check("addr early", 32'h0, 32'(addr));
        wb_xfer(1'b0, cbpc_pkg::REG_OE_LO, 32'h0, rd);
        check("oe lo reset", 32'h0000_00FF, rd);
        wb_xfer(1'b0, cbpc_pkg::REG_OE_HI, 32'h0, rd);
        check("oe hi reset", 32'h0000_000F, rd);
        pg <= 1'b1;
        wait_run(cbpc_pkg::POWERUP_MAX_NS / 40, "power-up");
        @(posedge clk_i);
        st <= {1'b1, 2'h2, 2'h0, 2'h2};
        check("freq", 32'h0, 32'(f100));
        check("addr", 32'h0000_00C6, 32'(addr));
        check("mode", 32'h0, 32'(mode));
        watch(24, seen);
        check("pin gating", 32'h0000_0FFB, 32'(seen));
        check("addr held", 32'h0000_00C6, 32'(addr));
        check("freq held", 32'h0, 32'(f100));
        wb_xfer(1'b0, cbpc_pkg::REG_CTRL, 32'h0, rd);
        check("ctrl", 32'h0000_0006, rd);
        wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        wb_xfer(1'b1, cbpc_pkg::REG_OE_LO, 32'h0000_00FE, rd);
        repeat (16) @(negedge clk_i);
        watch(24, seen);
        check("bit gating", 32'h0000_0FFA, 32'(seen));
        // Software bypass applies only after a power-down cycle
        wb_xfer(1'b1, cbpc_pkg::REG_CTRL, 32'h0000_000A, rd);
        wb_xfer(1'b0, cbpc_pkg::REG_CTRL, 32'h0, rd);
        check("ctrl override", 32'h0000_000A, rd);
        check("mode kept", 32'h0, 32'(mode));
        @(posedge clk_i);
        pg <= 1'b0;
        repeat (48) @(negedge clk_i);
        watch(16, seen);
        check("parked", 32'h0, 32'(seen));
        check("tristate", 32'h1, 32'(tri_st));
        ref_en <= 1'b0;
        wb_xfer(1'b0, cbpc_pkg::REG_OE_LO, 32'h0, rd);
        check("oe kept", 32'h0000_00FE, rd);
        @(posedge clk_i);
        ref_en <= 1'b1;
        pg <= 1'b1;
        wait_run(cbpc_pkg::RESTART_MAX_NS / 40, "restart");
        check("bypass mode", 32'h1, 32'(mode));
        check("pins back", 32'h0, 32'(tri_st));
        @(posedge clk_i);
        rst_i <= 1'b1;
        pg <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        pg <= 1'b1;
        wait_run(cbpc_pkg::POWERUP_MAX_NS / 40, "reboot");
        check("freq 100", 32'h1, 32'(f100));
        check("addr new", 32'h0000_00CA, 32'(addr));
        complete_run();
    end
endmodule : cbpc_tb_top
